// ===== verilog/tcc_top.sv
/*
  APB register bank for the transceiver I/O and clock configuration, with the decoded
  interface mode, direction, loopback, interpolation and clock-tree controls it steers.
  Assumes a single 10 MHz clock, an asynchronous active-low reset and an external
  direction pin that is asynchronous to the clock.
*/
// The APB register port was decided locally.
// Functional notes
// RQ1 - Interpolation code 01 gives 2x, 10 gives 4x
// RQ2 - Interpolation resets zero, both filter stages bypassed
// RQ3 - Loopback routes transmit path results to receive bus
// RQ4 - Software selects full duplex for loopback
// RQ5 - Duplex bit one is full duplex, resets one
// RQ6 - Duplex and width pick mode; mirror ignores duplex
// RQ7 - Direction bit one transmit, zero receive
// RQ8 - Width bit one 10-bit, zero 20-bit
// RQ9 - Override takes direction from bit, not pin
// RQ10 - Mirror bit enables mirror mode
// RQ11 - Software sets clock-mode field 111 for mirror
// RQ12 - Bypass routes reference around running loop
// RQ13 - Converter clock halved when set, resets zero
// RQ14 - Receive clock: reference normal, loop alternate
// RQ15 - Alternate timing resets zero, set selects loop
// RQ16 - Divide-by-five divides loop output, resets clear
// RQ17 - Transmit path clocked from loop after divider
// RQ18 - Multiplier resets 000; 000/001/010 give 1/2/4
// RQ19 - Loop output is reference times factor, over five; code divides by five only with divide-by-five set, else by one
// RQ20 - Other multiplier codes reserved and flagged
// RQ21 - Fields are plain read-write eight-bit bits
`timescale 1ns/1ps
module tcc_top
  import tcc_pkg::*;
(
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic [31:0]      PRDATA,
  // External direction pin
  input  wire logic        DIRECTION_PIN,
  // Interface controls
  output logic [1:0]       IF_MODE,
  output logic             TX_DIRECTION,
  output logic             LOOPBACK_ACTIVE,
  output logic             RX_BUS_FROM_TX_PATH,
  output logic             INTERP_STAGE1_EN,
  output logic             INTERP_STAGE2_EN,
  // Clock tree controls
  output logic             PLL_BYPASS,
  output logic             PLL_RUN,
  output logic             RX_CLK_FROM_PLL,
  output logic             RX_CLK_DIV2,
  output logic             TX_CLK_FROM_PLL,
  output logic             DIVIDE_BY_FIVE,
  output logic [4:0]       PLL_MULT_FACTOR,
  output logic [2:0]       PLL_OUT_DIVIDER,
  output logic             PLL_MULT_RESERVED
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0]   tx_path_r;
  logic [7:0]   tx_path_nxt;
  tcc_io_cfg_s  io_cfg_r;
  tcc_io_cfg_s  io_cfg_nxt;
  tcc_clk_cfg_s clk_cfg_r;
  tcc_clk_cfg_s clk_cfg_nxt;
  logic         pin_meta_r;
  logic         pin_sync_r;

  // ----------------------------------------------------------------------
  // Direction pin synchroniser
  // ----------------------------------------------------------------------
  // The pin is driven by the far side with no relation to SYS_CLK.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= DIRECTION_PIN;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // Zero wait states: the answer is raised for the access cycle itself.
  wire         setup_phase  = PSEL & ~PENABLE;
  wire         access_done  = PSEL & PENABLE & PREADY;
  wire         hit_tx_path  = (PADDR == TCC_ADDR_TX_PATH);
  wire         hit_io_cfg   = (PADDR == TCC_ADDR_IO_CFG);
  wire         hit_clk_cfg  = (PADDR == TCC_ADDR_CLK_CFG);
  wire         hit_status   = (PADDR == TCC_ADDR_STATUS);
  wire         hit_any      = hit_tx_path | hit_io_cfg | hit_clk_cfg | hit_status;
  wire         wr_done      = access_done & PWRITE;
  wire [7:0]   wr_byte      = PWDATA[7:0];

  // Status is read-only; a write to it is refused with an error.
  wire         bad_access   = ~hit_any | (PWRITE & hit_status);

  assign tx_path_nxt = (wr_done && hit_tx_path) ? (wr_byte & TCC_MASK_TX_PATH)
                                                : tx_path_r; // RQ21
  assign io_cfg_nxt  = (wr_done && hit_io_cfg)  ? tcc_io_cfg_s'(wr_byte & TCC_MASK_IO_CFG)
                                                : io_cfg_r; // RQ21
  assign clk_cfg_nxt = (wr_done && hit_clk_cfg) ? tcc_clk_cfg_s'(wr_byte & TCC_MASK_CLK_CFG)
                                                : clk_cfg_r; // RQ21

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_path_r <= TCC_RST_TX_PATH; // RQ2
      io_cfg_r  <= tcc_io_cfg_s'(TCC_RST_IO_CFG); // RQ5
      clk_cfg_r <= tcc_clk_cfg_s'(TCC_RST_CLK_CFG); // RQ13 RQ15 RQ16 RQ18
    end else begin
      tx_path_r <= tx_path_nxt;
      io_cfg_r  <= io_cfg_nxt;
      clk_cfg_r <= clk_cfg_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Interface mode decode
  // ----------------------------------------------------------------------
  // Mirror mode wins outright, so the duplex bit is a don't-care there.
  wire [1:0] interp_code = tx_path_r[1:0];
  tcc_if_mode_e mode_nxt;
  assign mode_nxt = io_cfg_r.mirror_mode_enable ? TCC_MIRROR_MODE : // RQ10 RQ6
                    io_cfg_r.duplex_select      ? TCC_FULL_DUPLEX_MODE : // RQ5 RQ6
                    io_cfg_r.bus_width_select   ? TCC_HALF_DUPLEX_NARROW_MODE : // RQ8
                                                  TCC_HALF_DUPLEX_WIDE_MODE; // RQ8

  // Direction is meaningful only in the half-duplex modes.
  wire       half_duplex  = (mode_nxt == TCC_HALF_DUPLEX_NARROW_MODE) ||
                            (mode_nxt == TCC_HALF_DUPLEX_WIDE_MODE);
  wire       dir_source   = io_cfg_r.io_override ? io_cfg_r.direction_select // RQ9 RQ7
                                                 : pin_sync_r; // RQ9
  wire       dir_nxt      = half_duplex & dir_source; // RQ7

  // Loopback is only defined with full-duplex timing; any other mode keeps it off.
  wire       loop_nxt     = io_cfg_r.loopback_enable &
                            (mode_nxt == TCC_FULL_DUPLEX_MODE); // RQ3 RQ4

  // Code 11 is not defined; it is treated as bypass rather than guessed at.
  wire       stage1_nxt   = (interp_code == TCC_INTERP_X2) ||
                            (interp_code == TCC_INTERP_X4); // RQ1 RQ2
  wire       stage2_nxt   = (interp_code == TCC_INTERP_X4); // RQ1

  // ----------------------------------------------------------------------
  // Clock tree decode
  // ----------------------------------------------------------------------
  logic [4:0] factor_nxt;
  logic       reserved_nxt;
  always_comb begin
    factor_nxt   = TCC_FACTOR_ONE;
    reserved_nxt = 1'b0;
    case (clk_cfg_r.multiplier)
      TCC_MULT_X1: factor_nxt = TCC_FACTOR_ONE; // RQ18
      TCC_MULT_X2: factor_nxt = TCC_FACTOR_TWO; // RQ18
      TCC_MULT_X4: factor_nxt = TCC_FACTOR_FOUR; // RQ18
      // Reserved codes fall back to unity and are reported, never acted on.
      default: begin
        factor_nxt   = TCC_FACTOR_ONE; // RQ20
        reserved_nxt = 1'b1; // RQ20
      end
    endcase
  end

  wire [2:0] divider_nxt = clk_cfg_r.divide_by_five ? TCC_DIVIDER_FIVE
                                                    : TCC_DIVIDER_ONE; // RQ16 RQ19

  // ----------------------------------------------------------------------
  // Status word and read data
  // ----------------------------------------------------------------------
  wire [7:0] status_word = {pin_sync_r, PLL_MULT_RESERVED, RX_BUS_FROM_TX_PATH,
                            LOOPBACK_ACTIVE, TX_DIRECTION, 1'b0, IF_MODE};

  wire [7:0] rd_byte = hit_tx_path ? tx_path_r :
                       hit_io_cfg  ? io_cfg_r :
                       hit_clk_cfg ? clk_cfg_r :
                       hit_status  ? status_word :
                                     8'h00;

  // ----------------------------------------------------------------------
  // Bus answer registers
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= setup_phase;
      PSLVERR <= setup_phase & bad_access;
      PRDATA  <= (setup_phase && !PWRITE) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------------
  // All outputs are registered, so each follows its register one cycle late.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      IF_MODE             <= TCC_FULL_DUPLEX_MODE;
      TX_DIRECTION        <= 1'b0;
      LOOPBACK_ACTIVE     <= 1'b0;
      RX_BUS_FROM_TX_PATH <= 1'b0;
      INTERP_STAGE1_EN    <= 1'b0;
      INTERP_STAGE2_EN    <= 1'b0;
      PLL_BYPASS          <= 1'b0;
      PLL_RUN             <= 1'b1;
      RX_CLK_FROM_PLL     <= 1'b0;
      RX_CLK_DIV2         <= 1'b0;
      TX_CLK_FROM_PLL     <= 1'b1;
      DIVIDE_BY_FIVE            <= 1'b0;
      PLL_MULT_FACTOR     <= TCC_FACTOR_ONE;
      PLL_OUT_DIVIDER     <= TCC_DIVIDER_ONE;
      PLL_MULT_RESERVED   <= 1'b0;
    end else begin
      IF_MODE             <= mode_nxt; // RQ6
      TX_DIRECTION        <= dir_nxt; // RQ7
      LOOPBACK_ACTIVE     <= loop_nxt; // RQ3
      RX_BUS_FROM_TX_PATH <= loop_nxt; // RQ3
      INTERP_STAGE1_EN    <= stage1_nxt; // RQ1
      INTERP_STAGE2_EN    <= stage2_nxt; // RQ1
      PLL_BYPASS          <= clk_cfg_r.pll_bypass; // RQ12
      PLL_RUN             <= 1'b1; // RQ12
      RX_CLK_FROM_PLL     <= clk_cfg_r.alt_timing; // RQ14 RQ15
      RX_CLK_DIV2         <= clk_cfg_r.rx_clock_div2; // RQ13
      TX_CLK_FROM_PLL     <= 1'b1; // RQ17
      DIVIDE_BY_FIVE            <= clk_cfg_r.divide_by_five; // RQ16 RQ17
      PLL_MULT_FACTOR     <= factor_nxt; // RQ19
      PLL_OUT_DIVIDER     <= divider_nxt; // RQ19
      PLL_MULT_RESERVED   <= reserved_nxt; // RQ20
    end
  end

endmodule : tcc_top

// ===== verilog/tcc_pkg.sv
/*
  Package for the transceiver I/O and clock configuration block: register indices, byte
  addresses, field positions, reset values, write masks and the carrier types.
  Assumes a 32-bit APB with each register in one aligned word at four times its index.
*/
package tcc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  TCC_IDX_TX_PATH   = 8'h0d;
  localparam logic [7:0]  TCC_IDX_IO_CFG    = 8'h0e;
  localparam logic [7:0]  TCC_IDX_CLK_CFG   = 8'h0f;
  localparam logic [7:0]  TCC_IDX_STATUS    = 8'h12;
  localparam logic [11:0] TCC_ADDR_TX_PATH  = {2'h0, TCC_IDX_TX_PATH, 2'h0};
  localparam logic [11:0] TCC_ADDR_IO_CFG   = {2'h0, TCC_IDX_IO_CFG, 2'h0};
  localparam logic [11:0] TCC_ADDR_CLK_CFG  = {2'h0, TCC_IDX_CLK_CFG, 2'h0};
  localparam logic [11:0] TCC_ADDR_STATUS   = {2'h0, TCC_IDX_STATUS, 2'h0};

  // ----------------------------------------------------------------------
  // Reset values and writable bits
  // ----------------------------------------------------------------------
  localparam logic [7:0]  TCC_RST_TX_PATH   = 8'h00;
  localparam logic [7:0]  TCC_RST_IO_CFG    = 8'h10;
  localparam logic [7:0]  TCC_RST_CLK_CFG   = 8'h00;
  localparam logic [7:0]  TCC_MASK_TX_PATH  = 8'h03;
  localparam logic [7:0]  TCC_MASK_IO_CFG   = 8'h3f;
  localparam logic [7:0]  TCC_MASK_CLK_CFG  = 8'hbf;

  // ----------------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------------
  localparam logic [1:0]  TCC_INTERP_X2     = 2'h1;
  localparam logic [1:0]  TCC_INTERP_X4     = 2'h2;
  localparam logic [2:0]  TCC_MULT_X1       = 3'h0;
  localparam logic [2:0]  TCC_MULT_X2       = 3'h1;
  localparam logic [2:0]  TCC_MULT_X4       = 3'h2;
  localparam logic [4:0]  TCC_FACTOR_ONE    = 5'h01;
  localparam logic [4:0]  TCC_FACTOR_TWO    = 5'h02;
  localparam logic [4:0]  TCC_FACTOR_FOUR   = 5'h04;
  localparam logic [2:0]  TCC_DIVIDER_ONE   = 3'h1;
  localparam logic [2:0]  TCC_DIVIDER_FIVE  = 3'h5;

  typedef enum logic [1:0] {
    TCC_FULL_DUPLEX_MODE        = 2'b00,
    TCC_HALF_DUPLEX_NARROW_MODE = 2'b01,
    TCC_HALF_DUPLEX_WIDE_MODE   = 2'b10,
    TCC_MIRROR_MODE             = 2'b11
  } tcc_if_mode_e;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] reserved;
    logic       loopback_enable;
    logic       duplex_select;
    logic       direction_select;
    logic       bus_width_select;
    logic       io_override;
    logic       mirror_mode_enable;
  } tcc_io_cfg_s;

  typedef struct packed {
    logic       pll_bypass;
    logic       reserved;
    logic       rx_clock_div2;
    logic       alt_timing;
    logic       divide_by_five;
    logic [2:0] multiplier;
  } tcc_clk_cfg_s;

endpackage : tcc_pkg

// ===== verification/tcc_properties.sv
/*
  Checker for tcc_top: APB answer timing and the controls decoded from register writes.
  Assumes it is bound to tcc_top, and that outputs settle two edges after a write is taken.
*/
`timescale 1ns/1ps
module tcc_properties
  import tcc_pkg::*;
(
  // Clock, reset and APB
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Decoded controls
  input wire logic [1:0]  IF_MODE,
  input wire logic        LOOPBACK_ACTIVE,
  input wire logic        RX_BUS_FROM_TX_PATH,
  input wire logic        INTERP_STAGE1_EN,
  input wire logic        INTERP_STAGE2_EN,
  input wire logic        PLL_BYPASS,
  input wire logic        PLL_RUN,
  input wire logic        RX_CLK_FROM_PLL,
  input wire logic        RX_CLK_DIV2,
  input wire logic        TX_CLK_FROM_PLL,
  input wire logic [4:0]  PLL_MULT_FACTOR,
  input wire logic [2:0]  PLL_OUT_DIVIDER
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire logic wr_done = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  wire logic io_wr   = wr_done && PADDR == TCC_ADDR_IO_CFG;
  wire logic clk_wr  = wr_done && PADDR == TCC_ADDR_CLK_CFG;
  wire logic tx_wr   = wr_done && PADDR == TCC_ADDR_TX_PATH;
  wire logic bad_req = !(PADDR inside {TCC_ADDR_TX_PATH, TCC_ADDR_IO_CFG, TCC_ADDR_CLK_CFG,
                         TCC_ADDR_STATUS}) || (PWRITE && PADDR == TCC_ADDR_STATUS);
  function automatic logic [1:0] mode_of(input logic [31:0] v);
    return v[0] ? 2'h3 : v[4] ? 2'h0 : v[2] ? 2'h1 : 2'h2;
  endfunction : mode_of
  function automatic logic [4:0] fac_of(input logic [31:0] v);
    return v[2:0] == 3'h0 ? 5'h01 : v[2:0] == 3'h1 ? 5'h02 : v[2:0] == 3'h2 ? 5'h04 : 5'h01;
  endfunction : fac_of
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  ready_answer_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready one cycle after setup");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready stood longer than one cycle");
  refuse_bad_a: assert property (PSEL && !PENABLE && bad_req |=> PSLVERR)
    else $error("unmapped access not refused");
  mode_decode_a: assert property (io_wr |-> ##2 IF_MODE == mode_of($past(PWDATA, 2)))
    else $error("interface mode wrong after write");
  loop_enable_a: assert property (io_wr |-> ##2 LOOPBACK_ACTIVE ==
    ($past(PWDATA[5], 2) && mode_of($past(PWDATA, 2)) == 2'h0))
    else $error("loopback wrong after write");
  loop_bus_a: assert property (RX_BUS_FROM_TX_PATH == LOOPBACK_ACTIVE)
    else $error("receive bus source disagrees with loopback");
  interp_rate_a: assert property (tx_wr |-> ##2 {INTERP_STAGE1_EN, INTERP_STAGE2_EN} ==
    {$past(PWDATA[1:0], 2) inside {2'h1, 2'h2}, $past(PWDATA[1:0], 2) == 2'h2})
    else $error("interpolation stages wrong after write");
  mult_factor_a: assert property (clk_wr |-> ##2
    PLL_MULT_FACTOR == fac_of($past(PWDATA, 2))
    && PLL_OUT_DIVIDER == ($past(PWDATA[3], 2) ? 3'h5 : 3'h1))
    else $error("loop factor or divider wrong after write");
  clock_bits_a: assert property (clk_wr |-> ##2
    {PLL_BYPASS, RX_CLK_DIV2, RX_CLK_FROM_PLL} ==
    {$past(PWDATA[7], 2), $past(PWDATA[5], 2), $past(PWDATA[4], 2)})
    else $error("clock tree bits wrong after write");
  loop_runs_a: assert property (PLL_RUN && TX_CLK_FROM_PLL)
    else $error("loop stopped or transmit clock not from loop");
  cover property (io_wr);
  cover property (clk_wr);
  cover property (PREADY && PSLVERR);
endmodule : tcc_properties

bind tcc_top tcc_properties tcc_properties_inst (.SYS_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PREADY, .PSLVERR, .IF_MODE, .LOOPBACK_ACTIVE, .RX_BUS_FROM_TX_PATH,
  .INTERP_STAGE1_EN, .INTERP_STAGE2_EN, .PLL_BYPASS, .PLL_RUN, .RX_CLK_FROM_PLL,
  .RX_CLK_DIV2, .TX_CLK_FROM_PLL, .PLL_MULT_FACTOR, .PLL_OUT_DIVIDER);

// ===== verification/tb_top.sv
/*
  Self-checking testbench for tcc_top, driving APB and the direction pin directly.
  Assumes nothing of the APB answer time; only the watchdog ends a wait for ready.
*/
`timescale 1ns/1ps
module tb_top
  import tcc_pkg::*;
;
  logic        SYS_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, DIRECTION_PIN = 0;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, rd;
  logic [1:0]  IF_MODE;
  logic [4:0]  PLL_MULT_FACTOR;
  logic [2:0]  PLL_OUT_DIVIDER;
  logic        PREADY, PSLVERR, er, TX_DIRECTION, LOOPBACK_ACTIVE, RX_BUS_FROM_TX_PATH;
  logic        INTERP_STAGE1_EN, INTERP_STAGE2_EN, PLL_BYPASS, PLL_RUN, RX_CLK_FROM_PLL;
  logic        RX_CLK_DIV2, TX_CLK_FROM_PLL, DIVIDE_BY_FIVE, PLL_MULT_RESERVED;
  int          bad_count = 0, total_checks = 0;
  tcc_top tcc_top_inst (.SYS_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY,
    .PSLVERR, .PRDATA, .DIRECTION_PIN, .IF_MODE, .TX_DIRECTION, .LOOPBACK_ACTIVE,
    .RX_BUS_FROM_TX_PATH, .INTERP_STAGE1_EN, .INTERP_STAGE2_EN, .PLL_BYPASS, .PLL_RUN,
    .RX_CLK_FROM_PLL, .RX_CLK_DIV2, .TX_CLK_FROM_PLL, .DIVIDE_BY_FIVE, .PLL_MULT_FACTOR,
    .PLL_OUT_DIVIDER, .PLL_MULT_RESERVED);
  initial forever #50 SYS_CLK = ~SYS_CLK;
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // Values are read in the edge's active region, before the design's updates land.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge SYS_CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic wrrd(input logic [11:0] a, input logic [7:0] d, input logic [7:0] m);
    apb(1'b1, a, d);
    repeat (2) @(posedge SYS_CLK);
    #1;
    apb(1'b0, a, 8'h0);
    chk(rd, {24'h0, d & m}, "readback");
    chk(er, 1'b0, "no error");
  endtask : wrrd
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, TCC_ADDR_TX_PATH, 8'h0);
    chk(rd, 32'h0, "tx path reset");
    apb(1'b0, TCC_ADDR_IO_CFG, 8'h0);
    chk(rd, 32'h10, "io reset");
    apb(1'b0, TCC_ADDR_CLK_CFG, 8'h0);
    chk(rd, 32'h0, "clock reset");
    chk({IF_MODE, TX_DIRECTION, LOOPBACK_ACTIVE}, 0, "idle io");
    chk({RX_BUS_FROM_TX_PATH, INTERP_STAGE1_EN, INTERP_STAGE2_EN}, 0, "idle path");
    chk({PLL_BYPASS, RX_CLK_FROM_PLL, RX_CLK_DIV2, PLL_MULT_RESERVED}, 0, "idle clocks");
    chk({PLL_RUN, TX_CLK_FROM_PLL}, 2'b11, "idle loop");
    chk({PLL_MULT_FACTOR, PLL_OUT_DIVIDER, DIVIDE_BY_FIVE}, {5'h1, 3'h1, 1'b0}, "loop reset");
  endtask : t_reset
  task automatic t_interp();
    for (int i = 0; i < 4; i++) begin
      wrrd(TCC_ADDR_TX_PATH, 8'(i), TCC_MASK_TX_PATH);
      chk({INTERP_STAGE1_EN, INTERP_STAGE2_EN}, {i == 1 || i == 2, i == 2}, "interp");
    end
  endtask : t_interp
  task automatic t_io();
    logic [7:0] v[10] = '{8'h10, 8'h14, 8'h04, 8'h00, 8'h11, 8'h01, 8'h30, 8'h24, 8'h0e, 8'hff};
    logic [1:0] m;
    foreach (v[k]) begin
      wrrd(TCC_ADDR_IO_CFG, v[k], TCC_MASK_IO_CFG);
      m = v[k][0] ? 2'h3 : v[k][4] ? 2'h0 : v[k][2] ? 2'h1 : 2'h2;
      chk(IF_MODE, m, "mode");
      chk(LOOPBACK_ACTIVE, v[k][5] && m == 2'h0, "loopback");
      chk(RX_BUS_FROM_TX_PATH, v[k][5] && m == 2'h0, "rx bus");
      chk(TX_DIRECTION, m inside {2'h1, 2'h2} && v[k][1] && v[k][3], "direction");
    end
  endtask : t_io
  task automatic t_pin();
    wrrd(TCC_ADDR_IO_CFG, 8'h04, TCC_MASK_IO_CFG);
    DIRECTION_PIN <= 1'b1;
    repeat (5) @(posedge SYS_CLK);
    #1;
    chk(TX_DIRECTION, 1'b1, "pin direction");
    apb(1'b0, TCC_ADDR_STATUS, 8'h0);
    chk(rd, 32'h89, "status");
    wrrd(TCC_ADDR_IO_CFG, 8'h06, TCC_MASK_IO_CFG);
    chk(TX_DIRECTION, 1'b0, "override direction");
  endtask : t_pin
  task automatic t_clk();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wrrd(TCC_ADDR_CLK_CFG, {c[0], 1'b1, c[1], c[2], c[0], c}, TCC_MASK_CLK_CFG);
      chk(PLL_MULT_FACTOR, c == 0 ? 1 : c == 1 ? 2 : c == 2 ? 4 : 1, "factor");
      chk(PLL_OUT_DIVIDER, c[0] ? 3'h5 : 3'h1, "divider");
      chk({PLL_BYPASS, RX_CLK_DIV2, RX_CLK_FROM_PLL, DIVIDE_BY_FIVE, PLL_MULT_RESERVED},
          {c[0], c[1], c[2], c[0], c > 2}, "clock bits");
      chk({PLL_RUN, TX_CLK_FROM_PLL}, 2'b11, "loop runs");
    end
  endtask : t_clk
  task automatic t_err();
    apb(1'b0, 12'hffc, 8'h0);
    chk(er, 1'b1, "unmapped read error");
    chk(rd, 32'h0, "unmapped read data");
    apb(1'b1, TCC_ADDR_STATUS, 8'h5a);
    chk(er, 1'b1, "status write");
    apb(1'b1, 12'h040, 8'h01);
    chk(er, 1'b1, "unmapped write");
  endtask : t_err
  // Every register holds a non-reset value here, so a mid-run reset must be seen.
  task automatic t_rerun();
    RST_N <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    t_reset();
  endtask : t_rerun
  // ----------------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    t_reset();
    t_interp();
    t_io();
    t_pin();
    t_clk();
    t_err();
    t_rerun();
    give_verdict();
  end
  initial begin
    #(100 * 5000);
    bad_count++;
    give_verdict();
  end
endmodule : tb_top
